// *** bpc_pkg.sv ***
package bpc_pkg;

   // fabric word width as configured on the transceiver side
   localparam int BPC_DEF_WIDTH = 40;

   // embedded generator latency in immediate mode
   localparam int BPC_GEN_LAT = 3;

   // link filter run length and comma idle count
   localparam int BPC_RUN_LEN = 7;
   localparam int BPC_RUN_W = 3;
   localparam logic [2:0] BPC_RUN_MAX = 3'h7;
   localparam logic [2:0] BPC_RUN_ZERO = 3'h0;
   localparam logic [2:0] BPC_IDLE_NEED = 3'h7;

   // checker polynomial taps: x^15 + x^14 + 1, fits the narrowest word
   localparam int BPC_TAP_A = 15;
   localparam int BPC_TAP_B = 14;

   // loopback buffer depth
   localparam int BPC_LB_DEPTH = 16;

   // recovered clock activity watchdog
   localparam int BPC_CLK_MHZ = 250;
   localparam int BPC_CLK_LOSS_NS = 1000;
   localparam int BPC_CLK_LOSS_CYC = (BPC_CLK_LOSS_NS * BPC_CLK_MHZ) / 1000;
   localparam int BPC_WDOG_W = 9;

   // statistics counters
   localparam int BPC_CNT_W = 32;
   localparam logic [31:0] BPC_CNT_ZERO = 32'h0000_0000;
   localparam logic [31:0] BPC_CNT_ONE = 32'h0000_0001;

   // framing states, gray along hunt -> gap -> data
   typedef enum logic [1:0] {
      BPC_FR_HUNT = 2'h0,
      BPC_FR_GAP = 2'h1,
      BPC_FR_DATA = 2'h3
   } bpc_frame_t;

endpackage

// *** bpc_channel.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: word width 16, 20, 32 or 40
// RULE_02: embedded generator matches transmit generator
// RULE_03: link and error checks every cycle
// RULE_04: framed: align, then find idle gaps
// RULE_05: framing machine stalls generator during gaps
// RULE_06: mode 1 immediate; reset/link-down forces it
// RULE_07: received word seeds generator, three-cycle result
// RULE_08: received pipeline cancels generator latency
// RULE_09: after link-up generator self-advances each cycle
// RULE_10: errors never disturb locked expected sequence
// RULE_11: seven clean cycles declare link-up
// RULE_12: seven all-errored cycles declare link-down
// RULE_13: mixed error patterns hold link status
// RULE_14: shared generator and transmit clock rate
// RULE_15: buffered receive clock plus clock-status flag; code gives only the o_rx_clk_ok flag, no clock output
// RULE_16: comma controller active only when enabled
// RULE_17: aligned after link-up and seven idles
// RULE_18: 32-bit bit-error counter, statistics clear
// RULE_19: 32-bit received-word counter, statistics clear
// RULE_20: word counter counts only with pll lock
// RULE_21: sixteen-deep loopback buffer to transmission
// RULE_22: buffer tolerates phase, not frequency offset
// RULE_23: remote sender frequency-locked for loopback
// RULE_24: idle words are comma-style gap fillers
// RULE_25: error count is popcount of xor
// RULE_26: reset gives link-down, run counters zero

////////////////////////////////////////////////////////////////////////////////
// loopback buffer, synchronous, valid/ready on both sides
module bpc_lb_fifo
   import bpc_pkg::*;
#(
   parameter int WIDTH = BPC_DEF_WIDTH,
   parameter int DEPTH = BPC_LB_DEPTH
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wptr_r;
   logic [AW:0] rptr_r;
   logic full;
   logic empty;
   logic do_wr;
   logic do_rd;

   // extra pointer bit separates full from empty
   assign empty = (wptr_r == rptr_r);
   assign full = (wptr_r[AW-1:0] == rptr_r[AW-1:0]) && (wptr_r[AW] != rptr_r[AW]);
   assign o_in_ready = ~full;
   assign o_out_valid = ~empty;
   assign do_wr = i_in_valid & ~full;
   assign do_rd = i_out_ready & ~empty;
   assign o_out_data = mem_r[rptr_r[AW-1:0]];

   // storage, no reset needed on data
   always_ff @(posedge i_sys_clk) begin
      if (do_wr) begin
         mem_r[wptr_r[AW-1:0]] <= i_in_data;
      end
   end

   // pointers
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         wptr_r <= '0;
         rptr_r <= '0;
      end else begin
         if (do_wr) begin
            wptr_r <= wptr_r + 1'b1;
         end
         if (do_rd) begin
            rptr_r <= rptr_r + 1'b1;
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// one checker channel: expected pattern, link filter, framing, comma, stats
module bpc_channel
   import bpc_pkg::*;
#(
   parameter int WIDTH = BPC_DEF_WIDTH,
   parameter int LB_DEPTH = BPC_LB_DEPTH
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_stat_clr,
   // receive fabric side
   input wire logic [WIDTH-1:0] i_rx_data,
   input wire logic i_rx_pll_locked,
   input wire logic i_recovered_line_clock,
   // framing
   input wire logic i_framed,
   input wire logic [WIDTH-1:0] i_idle_word,
   // comma alignment
   input wire logic i_comma_align_en,
   output logic o_plus_comma_align_on,
   output logic o_minus_comma_align_on,
   output logic o_aligned,
   // status
   output logic o_link_up,
   output logic o_immediate_mode,
   output logic o_rx_clk_ok,
   output logic o_in_gap,
   // statistics
   output logic [BPC_CNT_W-1:0] o_bit_err_cnt,
   output logic [BPC_CNT_W-1:0] o_rx_word_cnt,
   // loopback toward transmission
   input wire logic i_loopback_en,
   output logic o_lb_in_ready,
   output logic o_lb_valid,
   input wire logic i_lb_ready,
   output logic [WIDTH-1:0] o_lb_data
);
   localparam int PCW = $clog2(WIDTH + 1);

   // next word of the sequence from the previous word, bit 0 first in time
   function automatic logic [WIDTH-1:0] prbs_next(input logic [WIDTH-1:0] w);
      logic [2*WIDTH-1:0] ext;
      ext = {{WIDTH{1'b0}}, w};
      for (int j = WIDTH; j < 2 * WIDTH; j++) begin
         ext[j] = ext[j-BPC_TAP_A] ^ ext[j-BPC_TAP_B];
      end
      return ext[2*WIDTH-1:WIDTH];
   endfunction

   // set-bit count of the error vector
   function automatic logic [PCW-1:0] popcnt(input logic [WIDTH-1:0] v);
      logic [PCW-1:0] n;
      n = '0;
      for (int k = 0; k < WIDTH; k++) begin
         n = n + PCW'(v[k]);
      end
      return n;
   endfunction

   logic [WIDTH-1:0] seed_r;
   logic [WIDTH-1:0] seed2_r;
   logic [WIDTH-1:0] exp_r;
   logic [WIDTH-1:0] rx_d1_r;
   logic [WIDTH-1:0] rx_d2_r;
   logic [WIDTH-1:0] err_vec;
   logic [PCW-1:0] err_bits;
   logic cmp_idle;
   logic cmp_live;
   logic word_clean;
   logic link_up_r;
   logic [BPC_RUN_W-1:0] good_run_r;
   logic [BPC_RUN_W-1:0] bad_run_r;
   logic [BPC_RUN_W-1:0] good_run_nxt;
   logic [BPC_RUN_W-1:0] bad_run_nxt;
   bpc_frame_t frame_r;
   logic [BPC_RUN_W-1:0] idle_seen_r;
   logic aligned_r;
   logic [BPC_CNT_W-1:0] bit_err_cnt_r;
   logic [BPC_CNT_W-1:0] rx_word_cnt_r;
   logic pll_s1_r;
   logic pll_s2_r;
   logic rck_s1_r;
   logic rck_s2_r;
   logic rck_s3_r;
   logic [BPC_WDOG_W-1:0] wdog_r;

   ////////////////////////////////////////////////////////////////////////////
   // received path delayed two stages so it meets the three-cycle result
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         rx_d1_r <= '0;
         rx_d2_r <= '0;
      end else begin
         rx_d1_r <= i_rx_data; // RULE_01 RULE_08
         rx_d2_r <= rx_d1_r; // RULE_08
      end
   end

   // compared word is an idle filler in a framed stream
   assign cmp_idle = i_framed && (rx_d2_r == i_idle_word); // RULE_24 RULE_04
   // gap words add no bit errors and are not fed to the link filter; the idle that
   // closes a frame already belongs to the gap, so DATA must not let it through
   assign cmp_live = ~cmp_idle; // RULE_05

   ////////////////////////////////////////////////////////////////////////////
   // embedded generator: seed stage, hold stage, result stage
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         seed_r <= '0;
         seed2_r <= '0;
         exp_r <= '0;
      end else begin
         seed_r <= i_rx_data; // RULE_07
         seed2_r <= seed_r;
         if (~link_up_r) begin
            // immediate: re-seed from traffic every cycle until lock
            exp_r <= prbs_next(seed2_r); // RULE_02 RULE_06 RULE_07
         end else if (cmp_live) begin
            // locked: free-run, received words never feed back
            exp_r <= prbs_next(exp_r); // RULE_09 RULE_10
         end
         // locked and in a gap: hold the expected word
      end
   end

   // per-cycle error vector and its bit count
   assign err_vec = exp_r ^ rx_d2_r; // RULE_25
   assign err_bits = cmp_live ? popcnt(err_vec) : '0; // RULE_25 RULE_03
   assign word_clean = (err_vec == '0);

   ////////////////////////////////////////////////////////////////////////////
   // link filter run counters, saturating at the run length
   always_comb begin
      good_run_nxt = good_run_r;
      bad_run_nxt = bad_run_r;
      if (cmp_live) begin
         if (word_clean) begin
            good_run_nxt = (good_run_r == BPC_RUN_MAX) ? BPC_RUN_MAX : good_run_r + 1'b1; // RULE_11
            bad_run_nxt = BPC_RUN_ZERO;
         end else begin
            bad_run_nxt = (bad_run_r == BPC_RUN_MAX) ? BPC_RUN_MAX : bad_run_r + 1'b1; // RULE_12
            good_run_nxt = BPC_RUN_ZERO;
         end
      end
   end

   // link status changes only on a full run, otherwise holds
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         good_run_r <= BPC_RUN_ZERO; // RULE_26
         bad_run_r <= BPC_RUN_ZERO; // RULE_26
         link_up_r <= 1'b0; // RULE_26 RULE_06
      end else begin
         good_run_r <= good_run_nxt; // RULE_03
         bad_run_r <= bad_run_nxt;
         if (good_run_nxt == BPC_RUN_MAX) begin
            link_up_r <= 1'b1; // RULE_11
         end else if (bad_run_nxt == BPC_RUN_MAX) begin
            link_up_r <= 1'b0; // RULE_12
         end
         // any other mix keeps the status, filtering scattered errors RULE_13
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // framing machine: needs one idle to prove word alignment first
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || ~i_framed) begin
         frame_r <= BPC_FR_HUNT;
      end else begin
         unique case (frame_r)
            BPC_FR_HUNT: begin
               if (cmp_idle) begin
                  frame_r <= BPC_FR_GAP; // RULE_04
               end
            end
            BPC_FR_GAP: begin
               if (~cmp_idle) begin
                  frame_r <= BPC_FR_DATA; // RULE_05
               end
            end
            BPC_FR_DATA: begin
               if (cmp_idle) begin
                  frame_r <= BPC_FR_GAP; // RULE_05
               end
            end
            default: begin
               frame_r <= BPC_FR_HUNT;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // comma control: idles counted only once the checker is locked
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || ~i_comma_align_en) begin
         idle_seen_r <= BPC_RUN_ZERO; // RULE_16
         aligned_r <= 1'b0;
      end else begin
         if (link_up_r && (rx_d2_r == i_idle_word) && (idle_seen_r != BPC_IDLE_NEED)) begin
            idle_seen_r <= idle_seen_r + 1'b1;
         end
         if (link_up_r && (idle_seen_r == BPC_IDLE_NEED)) begin
            aligned_r <= 1'b1; // RULE_17
         end
      end
   end

   // transceiver comma alignment runs only while enabled and not yet aligned
   assign o_plus_comma_align_on = i_comma_align_en & ~aligned_r; // RULE_16 RULE_17
   assign o_minus_comma_align_on = i_comma_align_en & ~aligned_r; // RULE_16 RULE_17

   ////////////////////////////////////////////////////////////////////////////
   // pll lock pin crosses in through two flops
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         pll_s1_r <= 1'b0;
         pll_s2_r <= 1'b0;
      end else begin
         pll_s1_r <= i_rx_pll_locked;
         pll_s2_r <= pll_s1_r;
      end
   end

   // statistics: dedicated clear wins, and main reset clears them as well
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || i_stat_clr) begin
         bit_err_cnt_r <= BPC_CNT_ZERO; // RULE_18
         rx_word_cnt_r <= BPC_CNT_ZERO; // RULE_19
      end else begin
         bit_err_cnt_r <= bit_err_cnt_r + BPC_CNT_W'(err_bits); // RULE_18 RULE_03
         if (pll_s2_r) begin
            rx_word_cnt_r <= rx_word_cnt_r + BPC_CNT_ONE; // RULE_19 RULE_20
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // recovered clock activity: sampled pin, edge watchdog
   // a recovered clock near or above half our rate may alias; activity only
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         rck_s1_r <= 1'b0;
         rck_s2_r <= 1'b0;
         rck_s3_r <= 1'b0;
         wdog_r <= '0;
      end else begin
         rck_s1_r <= i_recovered_line_clock;
         rck_s2_r <= rck_s1_r;
         rck_s3_r <= rck_s2_r;
         if (rck_s2_r != rck_s3_r) begin
            wdog_r <= '0; // RULE_15
         end else if (wdog_r != BPC_WDOG_W'(BPC_CLK_LOSS_CYC)) begin
            wdog_r <= wdog_r + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // loopback: same clock on both ports, so phase only, never rate RULE_22
   bpc_lb_fifo #(
      .WIDTH(WIDTH),
      .DEPTH(LB_DEPTH)
   ) u_lb_fifo (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_in_valid(i_loopback_en), // RULE_21
      .o_in_ready(o_lb_in_ready),
      .i_in_data(i_rx_data),
      .o_out_valid(o_lb_valid),
      .i_out_ready(i_lb_ready), // RULE_14
      .o_out_data(o_lb_data)
   );

   // outputs
   assign o_link_up = link_up_r;
   assign o_immediate_mode = ~link_up_r; // RULE_06
   assign o_aligned = aligned_r; // RULE_17
   assign o_rx_clk_ok = (wdog_r != BPC_WDOG_W'(BPC_CLK_LOSS_CYC)); // RULE_15
   assign o_in_gap = (frame_r == BPC_FR_GAP); // RULE_05
   assign o_bit_err_cnt = bit_err_cnt_r;
   assign o_rx_word_cnt = rx_word_cnt_r;
endmodule

// *** bpc_channel_assertions.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// port-level watch on one checker channel
module bpc_channel_assertions
   import bpc_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_stat_clr,
   // inputs
   input wire logic i_rx_pll_locked,
   input wire logic i_comma_align_en,
   input wire logic i_loopback_en,
   // outputs
   input wire logic o_plus_comma_align_on,
   input wire logic o_minus_comma_align_on,
   input wire logic o_aligned,
   input wire logic o_link_up,
   input wire logic o_immediate_mode,
   input wire logic o_lb_in_ready,
   input wire logic o_lb_valid,
   input wire logic [BPC_CNT_W-1:0] o_bit_err_cnt,
   input wire logic [BPC_CNT_W-1:0] o_rx_word_cnt
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // reset must win even while held, so no disable here
   AST_RST: assert property (disable iff (1'h0) i_rst |=> !o_link_up && o_bit_err_cnt == 32'h0)
      else $error("link or error count not cleared by reset");
   AST_IMM: assert property (o_immediate_mode == !o_link_up)
      else $error("mode select disagrees with link status");
   // a rise needs six quiet updates before it
   AST_UP_RUN: assert property ($rose(o_link_up) |-> o_bit_err_cnt == $past(o_bit_err_cnt, 6))
      else $error("link rose after errored compares");
   AST_DN_RUN: assert property ($fell(o_link_up) |-> o_bit_err_cnt >= $past(o_bit_err_cnt, 6) + 32'h6)
      else $error("link fell without a run of errored compares");
   AST_CLR: assert property (i_stat_clr |=> o_bit_err_cnt == 32'h0 && o_rx_word_cnt == 32'h0)
      else $error("statistics clear ignored");
   // lock pin passes a two-flop sync, hence four samples
   AST_WC_RUN: assert property (i_rx_pll_locked [*4] ##0 !i_stat_clr |=> o_rx_word_cnt == $past(o_rx_word_cnt) + 32'h1)
      else $error("word counter missed a word under lock");
   AST_WC_HOLD: assert property ((!i_rx_pll_locked && !i_stat_clr) [*4] |=> $stable(o_rx_word_cnt))
      else $error("word counter moved without lock");
   AST_COMMA: assert property (o_plus_comma_align_on == (i_comma_align_en && !o_aligned) && o_minus_comma_align_on == o_plus_comma_align_on)
      else $error("comma enables wrong");
   AST_ALIGN: assert property ($rose(o_aligned) |-> $past(o_link_up) && $past(i_comma_align_en))
      else $error("aligned without link");
   AST_ALIGN_OFF: assert property (!i_comma_align_en |=> !o_aligned)
      else $error("aligned kept while disabled");
   AST_LB: assert property (i_loopback_en && o_lb_in_ready |=> o_lb_valid)
      else $error("loopback write not visible");
   COV_UP: cover property ($rose(o_link_up));
   COV_DN: cover property ($fell(o_link_up));
   COV_AL: cover property ($rose(o_aligned));
   COV_FULL: cover property (!o_lb_in_ready);
endmodule

bind bpc_channel bpc_channel_assertions u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_stat_clr(i_stat_clr),
   .i_rx_pll_locked(i_rx_pll_locked), .i_comma_align_en(i_comma_align_en), .i_loopback_en(i_loopback_en),
   .o_plus_comma_align_on(o_plus_comma_align_on), .o_minus_comma_align_on(o_minus_comma_align_on),
   .o_aligned(o_aligned), .o_link_up(o_link_up), .o_immediate_mode(o_immediate_mode),
   .o_lb_in_ready(o_lb_in_ready), .o_lb_valid(o_lb_valid), .o_bit_err_cnt(o_bit_err_cnt),
   .o_rx_word_cnt(o_rx_word_cnt));

// *** bpc_fabric_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// transceiver fabric side: prbs sender with idle gaps and error mask
module bpc_fabric_model
   import bpc_pkg::*;
(
   // clock
   input wire logic i_sys_clk,
   // bench controls
   input wire logic i_send_idle,
   input wire logic i_clk_run,
   input wire logic [39:0] i_err_mask,
   input wire logic [39:0] i_idle_word,
   // toward the channel
   output logic [39:0] o_rx_data,
   output logic o_rec_clk
);
   // top bits set: an all-zero register state would lock the sequence at zero
   logic [39:0] word_r = 40'hC0_0000_0001;
   initial o_rx_data = 40'h00_0000_0000;
   initial o_rec_clk = 1'h0;
   // serial x^15+x^14+1, bit 0 leaves first
   function automatic logic [39:0] prbs_next(input logic [39:0] w);
      logic [79:0] s;
      s = {40'h0, w};
      for (int j = 40; j < 80; j++) begin
         s[j] = s[j-14] ^ s[j-15];
      end
      return s[79:40];
   endfunction
   // sender on the local clock, so frequency-locked; gap holds the sequence
   always @(posedge i_sys_clk) begin
      if (i_send_idle) begin
         o_rx_data <= i_idle_word;
      end else begin
         word_r <= prbs_next(word_r);
         o_rx_data <= word_r ^ i_err_mask;
      end
   end
   // recovered clock stands still when stopped
   always @(posedge i_sys_clk) begin
      if (i_clk_run) begin
         o_rec_clk <= ~o_rec_clk;
      end
   end
endmodule

// *** bpc_channel_tb_top.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// bench for one checker channel fed by the fabric model
module bpc_channel_tb_top;
   import bpc_pkg::*;
   localparam logic [39:0] IDLE_W = 40'hFA_0FA_0FA_0;
   logic i_sys_clk = 1'h0;
   logic i_rst = 1'h1;
   logic stat_clr = 1'h0, pll = 1'h1, lb_en = 1'h0, lb_rdy = 1'h0, comma_en = 1'h1, idle = 1'h0, clk_run = 1'h1;
   logic framed = 1'h1;
   logic [39:0] mask = 40'h0, rx_data, lb_data;
   logic rec_clk, plus_on, minus_on, aligned, link_up, imm, clk_ok, in_gap, lb_in_rdy, lb_valid;
   logic [31:0] bit_err, words, w0;
   logic [39:0] q[$];
   int error_cnt = 0, samples_checked = 0, n;
   initial forever #2 i_sys_clk = ~i_sys_clk;
   bpc_channel dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_stat_clr(stat_clr), .i_rx_data(rx_data),
      .i_rx_pll_locked(pll), .i_recovered_line_clock(rec_clk), .i_framed(framed), .i_idle_word(IDLE_W),
      .i_comma_align_en(comma_en), .o_plus_comma_align_on(plus_on), .o_minus_comma_align_on(minus_on),
      .o_aligned(aligned), .o_link_up(link_up), .o_immediate_mode(imm), .o_rx_clk_ok(clk_ok), .o_in_gap(in_gap),
      .o_bit_err_cnt(bit_err), .o_rx_word_cnt(words), .i_loopback_en(lb_en), .o_lb_in_ready(lb_in_rdy),
      .o_lb_valid(lb_valid), .i_lb_ready(lb_rdy), .o_lb_data(lb_data));
   bpc_fabric_model u_far (.i_sys_clk(i_sys_clk), .i_send_idle(idle), .i_clk_run(clk_run), .i_err_mask(mask),
      .i_idle_word(IDLE_W), .o_rx_data(rx_data), .o_rec_clk(rec_clk));
   ////////////////////////////////////////////////////////////////////////////////
   // inputs move 1 ns after the edge to stay clear of sampling
   task automatic tick(input int k);
      repeat (k) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic chk_v(input string nm, input logic [39:0] exp, input logic [39:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task automatic chk_b(input string nm, input logic exp, input logic got);
      chk_v(nm, {39'h0, exp}, {39'h0, got});
   endtask
   task automatic end_sim();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // bounded wait; running out ends the run
   task automatic wait_link(input logic want);
      for (int k = 0; k < 40 && link_up !== want; k++) begin
         tick(1);
      end
      chk_b("link_up", want, link_up);
      if (link_up !== want) begin
         end_sim();
      end
   endtask
   task automatic clear_stats();
      stat_clr = 1'h1;
      tick(1);
      stat_clr = 1'h0;
      tick(4);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(3);
      i_rst = 1'h0;
      chk_b("link_up", 1'h0, link_up);
      chk_b("immediate", 1'h1, imm);
      chk_b("lb_in_ready", 1'h1, lb_in_rdy);
      wait_link(1'h1);
      chk_b("immediate", 1'h0, imm);
      chk_b("plus_comma", 1'h1, plus_on);
      clear_stats();
      chk_v("bit_err", 40'h0, 40'(bit_err));
      w0 = words;
      tick(10);
      chk_v("word_cnt", 40'(w0 + 32'hA), 40'(words));
      pll = 1'h0;
      tick(4);
      w0 = words;
      tick(10);
      chk_v("word_cnt", 40'(w0), 40'(words));
      pll = 1'h1;
      // gap of idles: generator must hold across it
      idle = 1'h1;
      tick(7);
      chk_b("in_gap", 1'h1, in_gap);
      tick(2);
      idle = 1'h0;
      tick(12);
      chk_b("aligned", 1'h1, aligned);
      chk_b("minus_comma", 1'h0, minus_on);
      chk_v("bit_err", 40'h0, 40'(bit_err));
      comma_en = 1'h0;
      tick(2);
      chk_b("aligned", 1'h0, aligned);
      comma_en = 1'h1;
      tick(1);
      chk_b("plus_comma", 1'h1, plus_on);
      // a second gap straight after data: its first idle must not be compared
      idle = 1'h1;
      tick(5);
      chk_b("in_gap", 1'h1, in_gap);
      idle = 1'h0;
      tick(8);
      chk_v("bit_err", 40'h0, 40'(bit_err));
      chk_b("link_up", 1'h1, link_up);
      // scattered three-bit errors every other word
      clear_stats();
      for (int k = 0; k < 10; k++) begin
         mask = 40'h00_0001_0101;
         tick(1);
         mask = 40'h0;
         tick(1);
      end
      tick(16);
      chk_v("bit_err", 40'h1E, 40'(bit_err));
      chk_b("link_up", 1'h1, link_up);
      // six errored words then clean: status holds
      mask = 40'hFF_FFFF_FFFF;
      tick(6);
      mask = 40'h0;
      tick(12);
      chk_b("link_up", 1'h1, link_up);
      mask = 40'hFF_FFFF_FFFF;
      wait_link(1'h0);
      chk_b("immediate", 1'h1, imm);
      mask = 40'h0;
      wait_link(1'h1);
      // unframed: idles are compared and the generator keeps running past them
      framed = 1'h0;
      clear_stats();
      idle = 1'h1;
      tick(3);
      idle = 1'h0;
      tick(4);
      chk_b("in_gap", 1'h0, in_gap);
      chk_b("unframed_err", 1'h1, bit_err != 32'h0);
      wait_link(1'h0);
      wait_link(1'h1);
      framed = 1'h1;
      // fill loopback with far side stalled, then drain
      lb_en = 1'h1;
      for (int k = 0; k < 20; k++) begin
         if (lb_in_rdy === 1'h1) begin
            q.push_back(rx_data);
         end
         tick(1);
      end
      lb_en = 1'h0;
      chk_v("lb_fill", 40'h10, 40'(q.size()));
      chk_b("lb_in_ready", 1'h0, lb_in_rdy);
      lb_rdy = 1'h1;
      for (n = 0; n < 40 && q.size() > 0; n++) begin
         if (lb_valid === 1'h1) begin
            chk_v("lb_data", q.pop_front(), lb_data);
         end
         tick(1);
      end
      chk_v("lb_left", 40'h0, 40'(q.size()));
      chk_b("lb_valid", 1'h0, lb_valid);
      // recovered clock stops, then returns
      clk_run = 1'h0;
      tick(300);
      chk_b("rx_clk_ok", 1'h0, clk_ok);
      clk_run = 1'h1;
      tick(10);
      chk_b("rx_clk_ok", 1'h1, clk_ok);
      // reset in mid-run
      i_rst = 1'h1;
      tick(2);
      i_rst = 1'h0;
      chk_b("link_up", 1'h0, link_up);
      chk_v("bit_err", 40'h0, 40'(bit_err));
      wait_link(1'h1);
      end_sim();
   end
endmodule
